// *** core/cts_tx_sched.sv ***
// CAN transmit buffers, request sources and buffer scheduler
//
// Local design decisions: the register addresses and strobed register access.
`default_nettype none

module cts_tx_sched
  import cts_pkg::*;
(
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       arst_n,
  // Register port
  input  wire logic [cts_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [cts_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [cts_pkg::DATA_W-1:0] reg_rdata,
  // Request pins and interrupt
  input  wire logic [cts_pkg::NUM_BUF-1:0] req_pin_n,
  output logic                             int_n,
  // Protocol engine link
  input  wire logic                       link_clk,
  input  wire logic                       link_bus_idle,
  input  wire logic                       link_done,
  input  wire logic                       link_error,
  input  wire logic                       link_arb_lost,
  input  wire logic [cts_pkg::IDX_W-1:0]  link_byte_idx,
  output logic                            tx_pending,
  output logic      [1:0]                 tx_buf_sel,
  output logic      [cts_pkg::DATA_W-1:0] tx_byte
);
  import cts_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage and state

  logic [7:0]          body_mem [NUM_BUF][BODY_LEN];
  logic [NUM_BUF-1:0]  treq_r;
  logic [NUM_BUF-1:0]  abort_flag_r;
  logic [NUM_BUF-1:0]  lost_r;
  logic [NUM_BUF-1:0]  transmit_error_flag_r;
  logic [PRIO_W-1:0]   prio_r [NUM_BUF];
  logic [NUM_BUF-1:0]  done_flag_r;
  logic                merr_flag_r;
  logic [NUM_BUF-1:0]  done_en_r;
  logic                merr_en_r;
  logic                one_shot_r;
  logic                abort_all_r;
  logic                config_r;
  logic [NUM_BUF-1:0]  rts_en_r;
  cts_state_t          state_r;
  logic [1:0]          sel_r;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers

  logic [NUM_BUF-1:0] pin_m_r, pin_s_r, pin_d_r;
  logic               lclk_m_r, lclk_s_r, lclk_d_r;
  logic               idle_m_r, idle_s_r;
  logic [2:0]         st_m_r, st_s_r;
  logic [IDX_W-1:0]   idx_m_r, idx_s_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_m_r  <= '1;
      pin_s_r  <= '1;
      pin_d_r  <= '1;
      lclk_m_r <= 1'b0;
      lclk_s_r <= 1'b0;
      lclk_d_r <= 1'b0;
      idle_m_r <= 1'b0;
      idle_s_r <= 1'b0;
      st_m_r   <= '0;
      st_s_r   <= '0;
      idx_m_r  <= '0;
      idx_s_r  <= '0;
    end else begin
      pin_m_r  <= req_pin_n;
      pin_s_r  <= pin_m_r;
      pin_d_r  <= pin_s_r;
      lclk_m_r <= link_clk;
      lclk_s_r <= lclk_m_r;
      lclk_d_r <= lclk_s_r;
      idle_m_r <= link_bus_idle;
      idle_s_r <= idle_m_r;
      st_m_r   <= {link_arb_lost, link_error, link_done};
      st_s_r   <= st_m_r;
      idx_m_r  <= link_byte_idx;
      idx_s_r  <= idx_m_r;
    end
  end

  // Engine outcomes are taken at rising link clock edges
  logic link_rise;
  logic ev_done, ev_err, ev_lost;
  assign link_rise = lclk_s_r & ~lclk_d_r;
  assign ev_done   = link_rise & st_s_r[0];
  assign ev_err    = link_rise & st_s_r[1] & ~st_s_r[0];
  assign ev_lost   = link_rise & st_s_r[2] & ~st_s_r[1] & ~st_s_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic                in_buf;
  logic [1:0]          buf_no;
  logic [3:0]          byte_no;
  assign buf_no  = reg_addr[BUF_SEL_LSB +: 2];
  assign byte_no = reg_addr[BUF_SEL_LSB-1:0];
  assign in_buf  = (reg_addr[ADDR_W-1:BUF_SEL_LSB+2] == '0) && (32'(buf_no) < NUM_BUF)
                   && (32'(byte_no) < BUF_BYTES);

  logic wr_buf_ctrl, wr_ctrl, wr_pin, wr_ie, wr_if, wr_rts;
  assign wr_buf_ctrl = reg_wr && in_buf && (byte_no == BYTE_CTRL);
  assign wr_ctrl     = reg_wr && (reg_addr == OFS_CTRL_REG);
  assign wr_pin      = reg_wr && (reg_addr == OFS_PIN_CTRL);
  assign wr_ie       = reg_wr && (reg_addr == OFS_INT_EN);
  assign wr_if       = reg_wr && (reg_addr == OFS_INT_FLAG);
  assign wr_rts      = reg_wr && (reg_addr == OFS_RTS_CMD);

  // identifier and data bytes after the control byte
  always_ff @(posedge core_clk) begin
    if (reg_wr && in_buf && (byte_no != BYTE_CTRL)) begin
      body_mem[buf_no][byte_no - 4'h1] <= reg_wdata;
    end
  end

  // Controller control and enables
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      one_shot_r  <= CTRL_RST[CC_ONESHOT];
      abort_all_r <= CTRL_RST[CC_ABORT_ALL];
      config_r    <= CTRL_RST[CC_CONFIG];
      done_en_r   <= '0;
      merr_en_r   <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        one_shot_r  <= reg_wdata[CC_ONESHOT];
        abort_all_r <= reg_wdata[CC_ABORT_ALL];
        config_r    <= reg_wdata[CC_CONFIG];
      end
      if (wr_ie) begin
        done_en_r <= reg_wdata[IE_DONE_LSB +: NUM_BUF];
        merr_en_r <= reg_wdata[IE_MERR];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rts_en_r <= '0;
    end else if (wr_pin && config_r) begin
      rts_en_r <= reg_wdata[PC_EN_LSB +: NUM_BUF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scheduler

  logic       any_ready;
  logic [1:0] best;

  // pick highest priority before frame start
  always_comb begin
    logic [PRIO_W-1:0] best_p;
    best_p    = '0;
    best      = 2'h0;
    any_ready = 1'b0;
    for (int n = 0; n < NUM_BUF; n++) begin
      // ties go to the higher number
      if (treq_r[n] && (!any_ready || (prio_r[n] >= best_p))) begin
        best_p    = prio_r[n];
        best      = 2'(n);
        any_ready = 1'b1;
      end
    end
  end

  logic active;
  assign active = (state_r == CTS_ACTIVE);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= CTS_IDLE;
      sel_r   <= 2'h0;
    end else begin
      case (state_r)
        CTS_IDLE: begin
          // start only with the bus free
          if (idle_s_r && any_ready && !abort_all_r) begin
            state_r <= CTS_ACTIVE;
            sel_r   <= best;
          end
        end
        CTS_ACTIVE: begin
          // frame on the bus runs to its outcome
          if (ev_done || ev_err || ev_lost) begin
            state_r <= CTS_IDLE;
          end
        end
        default: begin
          state_r <= CTS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-buffer control state

  logic [NUM_BUF-1:0] done_v, err_v, lost_v, give_up_v, sweep_v, new_req;

  generate
    for (genvar i = 0; i < NUM_BUF; i++) begin : g_buf
      logic mine, host_set, host_clr, pin_fall, cmd_set;
      assign mine     = active && (sel_r == 2'(i));
      assign done_v[i] = mine && ev_done;
      assign err_v[i]  = mine && ev_err;
      assign lost_v[i] = mine && ev_lost;
      // one-shot gives up after a failure
      // abort-all takes the frame only if it fails
      assign give_up_v[i] = (err_v[i] || lost_v[i]) && (one_shot_r || abort_all_r);
      // abort-all sweeps buffers not on the bus
      assign sweep_v[i] = abort_all_r && treq_r[i] && !mine;
      assign host_set = wr_buf_ctrl && (buf_no == 2'(i)) && reg_wdata[BIT_TREQ];
      assign host_clr = wr_buf_ctrl && (buf_no == 2'(i)) && !reg_wdata[BIT_TREQ];
      assign cmd_set  = wr_rts && reg_wdata[i];
      // falling edge of an enabled request pin
      assign pin_fall = rts_en_r[i] && pin_d_r[i] && !pin_s_r[i];
      assign new_req[i] = host_set || cmd_set || pin_fall;

      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          treq_r[i] <= 1'b0;
        end else if (new_req[i]) begin
          treq_r[i] <= 1'b1;
        end else if (host_clr || done_v[i] || give_up_v[i] || sweep_v[i]) begin
          treq_r[i] <= 1'b0;
        end
        // plain failure leaves the request set
      end

      // priority written with the request bit
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          prio_r[i] <= '0;
        end else if (wr_buf_ctrl && (buf_no == 2'(i))) begin
          prio_r[i] <= reg_wdata[PRIO_LSB +: PRIO_W];
        end
      end

      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          abort_flag_r[i]  <= 1'b0;
          lost_r[i]  <= 1'b0;
          transmit_error_flag_r[i] <= 1'b0;
        end else begin
          if (give_up_v[i] || sweep_v[i]) begin
            abort_flag_r[i] <= 1'b1;
          end else if (new_req[i]) begin
            abort_flag_r[i] <= 1'b0;
          end
          if (lost_v[i]) begin
            lost_r[i] <= 1'b1;
          end else if (new_req[i]) begin
            lost_r[i] <= 1'b0;
          end
          if (err_v[i]) begin
            transmit_error_flag_r[i] <= 1'b1;
          end else if (new_req[i]) begin
            transmit_error_flag_r[i] <= 1'b0;
          end
        end
      end

      // done flag, host writes 0 to clear
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          done_flag_r[i] <= 1'b0;
        end else if (done_v[i]) begin
          done_flag_r[i] <= 1'b1;
        end else if (wr_if && !reg_wdata[IE_DONE_LSB + i]) begin
          done_flag_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      merr_flag_r <= 1'b0;
    end else if (|err_v) begin
      merr_flag_r <= 1'b1;
    end else if (wr_if && !reg_wdata[IE_MERR]) begin
      merr_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // interrupt from enabled flags, active low
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_n <= 1'b1;
    end else begin
      int_n <= ~(|(done_flag_r & done_en_r) | (merr_flag_r & merr_en_r));
    end
  end

  // Engine side: selected buffer and requested frame byte
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_pending <= 1'b0;
      tx_buf_sel <= 2'h0;
      tx_byte    <= BYTE_ZERO;
    end else begin
      tx_pending <= active;
      tx_buf_sel <= sel_r;
      if (32'(idx_s_r) < BODY_LEN) begin
        tx_byte <= body_mem[sel_r][idx_s_r];
      end else begin
        tx_byte <= BYTE_ZERO;
      end
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= BYTE_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= BYTE_ZERO;
      if (in_buf && (byte_no == BYTE_CTRL)) begin
        reg_rdata[PRIO_LSB +: PRIO_W] <= prio_r[buf_no];
        reg_rdata[BIT_TREQ]           <= treq_r[buf_no];
        reg_rdata[BIT_TRANSMIT_ERROR_FLAG]          <= transmit_error_flag_r[buf_no];
        reg_rdata[BIT_LOST]           <= lost_r[buf_no];
        reg_rdata[BIT_ABORT_FLAG]           <= abort_flag_r[buf_no];
      end else if (in_buf) begin
        reg_rdata <= body_mem[buf_no][byte_no - 4'h1];
      end else if (reg_addr == OFS_CTRL_REG) begin
        reg_rdata[CC_ONESHOT]   <= one_shot_r;
        reg_rdata[CC_ABORT_ALL] <= abort_all_r;
        reg_rdata[CC_CONFIG]    <= config_r;
      end else if (reg_addr == OFS_PIN_CTRL) begin
        reg_rdata[PC_EN_LSB +: NUM_BUF]    <= rts_en_r;
        reg_rdata[PC_STATE_LSB +: NUM_BUF] <= pin_s_r;
      end else if (reg_addr == OFS_INT_EN) begin
        reg_rdata[IE_DONE_LSB +: NUM_BUF] <= done_en_r;
        reg_rdata[IE_MERR]                <= merr_en_r;
      end else if (reg_addr == OFS_INT_FLAG) begin
        reg_rdata[IE_DONE_LSB +: NUM_BUF] <= done_flag_r;
        reg_rdata[IE_MERR]                <= merr_flag_r;
      end
    end
  end

endmodule // cts_tx_sched

`default_nettype wire

// *** core/cts_pkg.sv ***
// Constants and types for the CAN transmit buffer scheduler
`default_nettype none

package cts_pkg;

  // Geometry
  localparam int NUM_BUF   = 3;
  localparam int BUF_BYTES = 14;
  localparam int BODY_LEN  = BUF_BYTES - 1;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 8;
  localparam int PRIO_W    = 2;
  localparam int IDX_W     = 4;

  // Address map: buffer n at n*16, control byte first
  localparam int          BUF_SEL_LSB  = 4;
  localparam logic [7:0]  OFS_CTRL_REG = 8'h30;
  localparam logic [7:0]  OFS_PIN_CTRL = 8'h31;
  localparam logic [7:0]  OFS_INT_EN   = 8'h32;
  localparam logic [7:0]  OFS_INT_FLAG = 8'h33;
  localparam logic [7:0]  OFS_RTS_CMD  = 8'h34;
  localparam logic [3:0]  BYTE_CTRL    = 4'h0;

  // tx_buffer_control fields
  localparam int PRIO_LSB  = 0;
  localparam int BIT_TREQ  = 3;
  localparam int BIT_TRANSMIT_ERROR_FLAG = 4;
  localparam int BIT_LOST  = 5;
  localparam int BIT_ABORT_FLAG  = 6;

  // controller_control_reg fields
  localparam int CC_ONESHOT   = 3;
  localparam int CC_ABORT_ALL = 4;
  localparam int CC_CONFIG    = 7;

  // request_pin_control fields
  localparam int PC_EN_LSB    = 0;
  localparam int PC_STATE_LSB = 3;

  // interrupt_enable_reg / interrupt_flag_reg fields
  localparam int IE_DONE_LSB = 0;
  localparam int IE_MERR     = 5;

  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h80;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [0:0] {
    CTS_IDLE   = 1'b0,
    CTS_ACTIVE = 1'b1
  } cts_state_t;

endpackage

`default_nettype wire

// *** testbench/cts_tx_sched_properties.sv ***
// Port-level properties of the transmit buffer scheduler
`default_nettype none

module cts_tx_sched_checker (
  // Clock and reset
  input wire logic                       core_clk,
  input wire logic                       arst_n,
  // Register port
  input wire logic [cts_pkg::ADDR_W-1:0] reg_addr,
  input wire logic                       reg_rd,
  input wire logic [cts_pkg::DATA_W-1:0] reg_rdata,
  // Engine link
  input wire logic                       link_clk,
  input wire logic                       link_done,
  input wire logic                       link_error,
  input wire logic                       link_arb_lost,
  input wire logic [cts_pkg::IDX_W-1:0]  link_byte_idx,
  input wire logic                       tx_pending,
  input wire logic [1:0]                 tx_buf_sel,
  input wire logic [cts_pkg::DATA_W-1:0] tx_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  import cts_pkg::*;

  logic ending;
  assign ending = link_done || link_error || link_arb_lost;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  sel_hold_a: assert property (tx_pending && $past(tx_pending) |-> $stable(tx_buf_sel))
    else $error("select moved in frame");
  sel_range_a: assert property (tx_pending |-> tx_buf_sel != 2'h3)
    else $error("no such buffer");
  unmapped_rd_a: assert property (reg_rd && reg_addr > OFS_RTS_CMD |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  cmd_rd_a: assert property (reg_rd && reg_addr == OFS_RTS_CMD |=> reg_rdata == 8'h00)
    else $error("command read not zero");
  rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved");
  tail_byte_a: assert property ((link_byte_idx >= 4'hD) [*5] |-> tx_byte == 8'h00)
    else $error("byte past body not zero");
  outcome_end_a: assert property ($rose(link_clk) && ending && tx_pending |-> ##[1:8] !tx_pending)
    else $error("frame not closed");
  no_early_drop_a: assert property ((!ending) [*6] ##0 tx_pending |=> tx_pending)
    else $error("frame dropped early");

endmodule // cts_tx_sched_checker

bind cts_tx_sched cts_tx_sched_checker i_chk (
  .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .link_clk(link_clk), .link_done(link_done),
  .link_error(link_error), .link_arb_lost(link_arb_lost), .link_byte_idx(link_byte_idx),
  .tx_pending(tx_pending), .tx_buf_sel(tx_buf_sel), .tx_byte(tx_byte));

`default_nettype wire

// *** testbench/cts_engine_model.sv ***
// Behavioural protocol engine on the far side of the scheduler
`default_nettype none

module cts_engine_model (
  // Scheduler side
  input  wire logic       core_clk,
  input  wire logic       tx_pending,
  input  wire logic [7:0] tx_byte,
  // Bench controls
  input  wire logic       bus_free,
  input  wire logic [1:0] outcome,
  input  wire logic [7:0] slow,
  // Engine link
  output logic            link_clk,
  output logic            link_bus_idle,
  output logic            link_done,
  output logic            link_error,
  output logic            link_arb_lost,
  output logic [3:0]      link_byte_idx,
  output logic [7:0]      body [0:12]
);
  timeunit 1ns;
  timeprecision 100ps;

  assign link_bus_idle = bus_free;

  initial begin
    link_clk      = 1'b0;
    link_done     = 1'b0;
    link_error    = 1'b0;
    link_arb_lost = 1'b0;
    link_byte_idx = 4'h0;
    forever begin
      @(posedge core_clk iff tx_pending);
      for (int i = 0; i < 13; i++) begin
        link_byte_idx <= 4'(i);
        repeat (6) @(posedge core_clk);
        body[i] = tx_byte;
      end
      // Past the body, zeros expected
      link_byte_idx <= 4'hF;
      repeat (slow) @(posedge core_clk);
      link_done     <= (outcome == 2'h0);
      link_error    <= (outcome == 2'h1);
      link_arb_lost <= (outcome == 2'h2);
      // One link period, off the core phase
      #20 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
      #62.5;
      link_done     <= 1'b0;
      link_error    <= 1'b0;
      link_arb_lost <= 1'b0;
    end
  end
endmodule // cts_engine_model

`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the transmit buffer scheduler
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import cts_pkg::*;

  typedef struct {
    logic [5:0] prio;
    logic [2:0] req;
    logic [5:0] order;
    int         n;
  } cts_row_t;

  // Priorities b2 b1 b0, send order with first in low bits
  cts_row_t rows [6] = '{
    '{6'h27, 3'h7, 6'h18, 3}, '{6'h15, 3'h7, 6'h06, 3}, '{6'h0F, 3'h7, 6'h21, 3},
    '{6'h0C, 3'h5, 6'h02, 2}, '{6'h02, 3'h7, 6'h18, 3}, '{6'h00, 3'h2, 6'h01, 1}};

  logic       core_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       bus_free = 1'b0, int_n, tx_pending, link_clk, link_bus_idle;
  logic       link_done, link_error, link_arb_lost;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, slow = 8'h00, reg_rdata, tx_byte;
  logic [7:0] body [0:12];
  logic [3:0] link_byte_idx;
  logic [2:0] req_pin_n = 3'h7;
  logic [1:0] outcome = 2'h0, tx_buf_sel;
  int         fails = 0, num_checks = 0;

  always #4 core_clk = ~core_clk;

  cts_tx_sched i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_pin_n(req_pin_n),
    .int_n(int_n), .link_clk(link_clk), .link_bus_idle(link_bus_idle),
    .link_done(link_done), .link_error(link_error), .link_arb_lost(link_arb_lost),
    .link_byte_idx(link_byte_idx), .tx_pending(tx_pending), .tx_buf_sel(tx_buf_sel),
    .tx_byte(tx_byte));

  cts_engine_model i_eng (
    .core_clk(core_clk), .tx_pending(tx_pending), .tx_byte(tx_byte), .bus_free(bus_free),
    .outcome(outcome), .slow(slow), .link_clk(link_clk), .link_bus_idle(link_bus_idle),
    .link_done(link_done), .link_error(link_error), .link_arb_lost(link_arb_lost),
    .link_byte_idx(link_byte_idx), .body(body));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pat(input int b, input int j);
    return 8'(b * 32 + j);
  endfunction

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_byte(what, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    chk_byte(what, exp, reg_rdata);
  endtask

  task automatic wait_pend(input logic v);
    for (int k = 0; k < 400; k++) begin
      @(posedge core_clk);
      if (tx_pending === v) break;
    end
    chk_bit("tx_pending", v, tx_pending);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Run needs about 20 us
  initial begin
    #100000;
    fails++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int b = 0; b < 3; b++)
      for (int j = 1; j < 14; j++) reg_write(8'(b * 16 + j), pat(b, j));
    reg_write(OFS_INT_EN, 8'h07);
    foreach (rows[r]) begin
      slow <= 8'((r % 2) * 40);
      for (int b = 0; b < 3; b++)
        if (rows[r].req[b]) reg_write(8'(b * 16), 8'h08 | 8'(rows[r].prio[2*b +: 2]));
      bus_free <= 1'b1;
      for (int k = 0; k < rows[r].n; k++) begin
        wait_pend(1'b1);
        chk_byte("tx_buf_sel", 8'(rows[r].order[2*k +: 2]), 8'(tx_buf_sel));
        wait_pend(1'b0);
        for (int j = 0; j < 13; j++) chk_byte("body", pat(rows[r].order[2*k +: 2], j + 1), body[j]);
      end
      bus_free <= 1'b0;
      chk_bit("int_n", 1'b0, int_n);
      reg_check(OFS_INT_FLAG, 8'(rows[r].req), "done flags");
      for (int b = 0; b < 3; b++)
        if (rows[r].req[b]) reg_check(8'(b * 16), 8'(rows[r].prio[2*b +: 2]), "control");
      reg_write(OFS_INT_FLAG, 8'h00);
      repeat (2) @(posedge core_clk);
      chk_bit("int_n", 1'b1, int_n);
      $display("test row %0d done", r);
    end
    // Second reset, then defaults
    arst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    reg_check(OFS_CTRL_REG, CTRL_RST, "controller control");
    reg_check(OFS_PIN_CTRL, 8'h38, "pin control");
    reg_check(OFS_RTS_CMD, 8'h00, "request command");
    reg_write(8'h41, 8'h5A);
    reg_check(8'h41, 8'h00, "unmapped");
    reg_check(8'h01, pat(0, 1), "body 0 byte 1");
    reg_check(8'h20, 8'h00, "control 2");
    $display("test reset done");
    reg_write(OFS_PIN_CTRL, 8'h01);
    reg_write(OFS_CTRL_REG, 8'h00);
    reg_write(OFS_PIN_CTRL, 8'h00);
    reg_check(OFS_PIN_CTRL, 8'h39, "pin control");
    req_pin_n <= 3'h4;
    repeat (6) @(posedge core_clk);
    reg_check(8'h00, 8'h08, "control 0");
    reg_check(8'h10, 8'h00, "control 1");
    reg_check(OFS_PIN_CTRL, 8'h21, "pin control");
    req_pin_n <= 3'h7;
    reg_write(OFS_RTS_CMD, 8'h06);
    reg_check(8'h10, 8'h08, "control 1");
    reg_check(8'h20, 8'h08, "control 2");
    $display("test request sources done");
    reg_write(8'h20, 8'h00);
    reg_check(8'h20, 8'h00, "control 2");
    reg_write(OFS_CTRL_REG, 8'h10);
    reg_check(8'h00, 8'h40, "control 0");
    reg_check(8'h10, 8'h40, "control 1");
    reg_write(OFS_CTRL_REG, 8'h00);
    reg_write(8'h00, 8'h08);
    reg_check(8'h00, 8'h08, "control 0");
    $display("test abort done");
    reg_write(OFS_INT_EN, 8'h20);
    outcome  <= 2'h1;
    slow     <= 8'h00;
    bus_free <= 1'b1;
    wait_pend(1'b1);
    reg_write(OFS_CTRL_REG, 8'h10);
    wait_pend(1'b0);
    reg_check(8'h00, 8'h50, "control 0");
    reg_check(OFS_INT_FLAG, 8'h20, "flags");
    chk_bit("int_n", 1'b0, int_n);
    reg_write(OFS_INT_FLAG, 8'h00);
    reg_write(OFS_CTRL_REG, 8'h00);
    outcome <= 2'h2;
    reg_write(8'h10, 8'h0B);
    wait_pend(1'b1);
    wait_pend(1'b0);
    outcome <= 2'h0;
    reg_check(8'h10, 8'h2B, "control 1");
    wait_pend(1'b1);
    chk_byte("retry buffer", 8'h01, 8'(tx_buf_sel));
    wait_pend(1'b0);
    reg_check(OFS_INT_FLAG, 8'h02, "flags");
    $display("test outcomes done");
    reg_write(OFS_CTRL_REG, 8'h08);
    outcome  <= 2'h1;
    bus_free <= 1'b0;
    reg_write(8'h20, 8'h08);
    repeat (30) @(posedge core_clk);
    chk_bit("tx_pending", 1'b0, tx_pending);
    bus_free <= 1'b1;
    wait_pend(1'b1);
    wait_pend(1'b0);
    reg_check(8'h20, 8'h50, "control 2");
    repeat (40) @(posedge core_clk);
    chk_bit("tx_pending", 1'b0, tx_pending);
    $display("test one shot done");
    summarize();
  end
endmodule // testbench

`default_nettype wire
